// ### logic/value_hold_bank.sv
// Purpose: bank of 32 edge-triggered signed value holding cells
// Assumes: markers and analog words are presented as parallel inputs
// Notes: retention count picks the lowest-numbered cells as retentive
`timescale 1ns/1ns
`include "value_hold_cfg.svh"
module value_hold_bank (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic run_mode,
  input wire logic [`VH_RET_W-1:0] retentive_count,
  input wire logic [`VH_CELLS-1:0] transfer_strobe,
  input wire logic [`VH_CELLS*`VH_SEL_W-1:0] operand_select,
  input wire logic [`VH_CELLS*`VH_DATA_W-1:0] const_operand,
  input wire logic [`VH_CELLS*8-1:0] marker_byte,
  input wire logic [`VH_CELLS*16-1:0] marker_word,
  input wire logic [`VH_CELLS*`VH_DATA_W-1:0] marker_dword,
  input wire logic [`VH_CELLS*`VH_IDX_W-1:0] block_select,
  input wire logic [`VH_CELLS*`VH_DATA_W-1:0] block_value,
  input wire value_hold_pkg::hold_word_t analog_in_first,
  input wire value_hold_pkg::hold_word_t analog_in_second,
  input wire value_hold_pkg::hold_word_t analog_in_third,
  input wire value_hold_pkg::hold_word_t analog_in_fourth,
  input wire value_hold_pkg::hold_word_t analog_out_first,
  input wire logic [`VH_IDX_W-1:0] analog_out_cell,
  input wire logic analog_out_enable,
  input wire logic [`VH_CELLS*2-1:0] output_route,
  output logic [`VH_CELLS-1:0] transfer_ack_contact,
  output logic [`VH_CELLS*`VH_DATA_W-1:0] held_value_out,
  output value_hold_pkg::hold_word_t analog_out_value,
  output logic analog_out_valid,
  output logic [`VH_CELLS*8-1:0] marker_byte_out,
  output logic [`VH_CELLS*16-1:0] marker_word_out,
  output logic [`VH_CELLS*`VH_DATA_W-1:0] marker_dword_out
);
  import value_hold_pkg::*;

  // selects one cell's operand; used for every cell
  function automatic hold_word_t pick_operand(
    input operand_src_t src,
    input hold_word_t kval,
    input logic [7:0] mb,
    input logic [15:0] mw,
    input hold_word_t md,
    input hold_word_t blk,
    input hold_word_t a1,
    input hold_word_t a2,
    input hold_word_t a3,
    input hold_word_t a4,
    input hold_word_t ao
  );
    unique case (src)
      SRC_CONST: pick_operand = kval;
      SRC_MARKER_BYTE: pick_operand = {{24{mb[7]}}, mb};
      SRC_MARKER_WORD: pick_operand = {{16{mw[15]}}, mw};
      SRC_MARKER_DWORD: pick_operand = md;
      SRC_ANALOG_IN_1: pick_operand = a1;
      SRC_ANALOG_IN_2: pick_operand = a2;
      SRC_ANALOG_IN_3: pick_operand = a3;
      SRC_ANALOG_IN_4: pick_operand = a4;
      SRC_ANALOG_OUT: pick_operand = ao;
      SRC_BLOCK_VALUE: pick_operand = blk;
      default: pick_operand = kval;
    endcase
  endfunction : pick_operand

  logic [`VH_CELLS-1:0] strobe_m1_r, strobe_m2_r, strobe_m3_r;
  logic [`VH_CELLS-1:0] strobe_sync_r;
  logic [`VH_CELLS-1:0] ack;
  hold_word_t cell_value [`VH_CELLS];

  // triggers arrive from outside the clock domain: three stages
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strobe_m1_r <= '0;
      strobe_m2_r <= '0;
      strobe_m3_r <= '0;
      strobe_sync_r <= '0;
    end else if (clk_en) begin
      strobe_m1_r <= transfer_strobe;
      strobe_m2_r <= strobe_m1_r;
      strobe_m3_r <= strobe_m2_r;
      // only stages two and three vote; stage one may still be metastable
      for (int i = 0; i < `VH_CELLS; i++) begin
        if (strobe_m2_r[i] == strobe_m3_r[i]) begin
          strobe_sync_r[i] <= strobe_m3_r[i];
        end
      end
    end
  end

  for (genvar g = 0; g < `VH_CELLS; g++) begin : g_cell
    hold_word_t operand;
    logic is_ret;
    assign is_ret = (`VH_RET_W'(g) < retentive_count);
    assign operand = pick_operand(
      operand_src_t'(operand_select[g*`VH_SEL_W +: `VH_SEL_W]),
      const_operand[g*`VH_DATA_W +: `VH_DATA_W],
      marker_byte[g*8 +: 8],
      marker_word[g*16 +: 16],
      marker_dword[g*`VH_DATA_W +: `VH_DATA_W],
      block_value[block_select[g*`VH_IDX_W +: `VH_IDX_W]*`VH_DATA_W
        +: `VH_DATA_W],
      analog_in_first, analog_in_second, analog_in_third,
      analog_in_fourth, analog_out_first);

    value_hold_cell u_cell (
      .clk_sys(clk_sys),
      .reset(reset),
      .clk_en(clk_en),
      .retentive(is_ret),
      .run_mode(run_mode),
      .transfer_strobe(strobe_sync_r[g]),
      .capture_operand(operand),
      .transfer_ack(ack[g]),
      .held_value_out(cell_value[g])
    );

    assign held_value_out[g*`VH_DATA_W +: `VH_DATA_W] = cell_value[g];
    assign transfer_ack_contact[g] = ack[g];
  end

  // output routing registered so data outputs come from flip-flops
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      marker_byte_out <= '0;
      marker_word_out <= '0;
      marker_dword_out <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < `VH_CELLS; i++) begin
        unique case (value_dst_t'(output_route[i*2 +: 2]))
          DST_MARKER_BYTE: marker_byte_out[i*8 +: 8] <= cell_value[i][7:0];
          DST_MARKER_WORD:
            marker_word_out[i*16 +: 16] <= cell_value[i][15:0];
          DST_MARKER_DWORD:
            marker_dword_out[i*`VH_DATA_W +: `VH_DATA_W] <= cell_value[i];
          DST_ANALOG_OUT: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      analog_out_value <= `VH_CLEAR_VALUE;
      analog_out_valid <= 1'b0;
    end else if (clk_en) begin
      analog_out_valid <= analog_out_enable;
      if (analog_out_enable) begin
        analog_out_value <= cell_value[analog_out_cell];
      end
    end
  end

  // settled pin levels reach every ack contact one edge later
  property p_ack_follows_trigger;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && strobe_m2_r == strobe_m3_r) |=>
        transfer_ack_contact == $past(strobe_m3_r);
  endproperty
  a_ack_follows_trigger: assert property (p_ack_follows_trigger)
    else $error("ack contact differs from trigger");

  // a half-settled pin level must not reach the cells
  sequence s_stage_split0;
    clk_en && strobe_m2_r[0] != strobe_m3_r[0];
  endsequence
  property p_sync_hold;
    @(posedge clk_sys) disable iff (reset)
      s_stage_split0 |=>
        transfer_ack_contact[0] == $past(transfer_ack_contact[0]);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("ack moved while synchroniser stages disagreed");

  property p_route_dword;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && output_route[3:2] == 2'h3) |=>
        marker_dword_out[63:32] == $past(cell_value[1]);
  endproperty
  a_route_dword: assert property (p_route_dword)
    else $error("dword marker of cell 1 does not follow its value");

  sequence s_analog_req;
    clk_en && analog_out_enable;
  endsequence
  property p_analog_out;
    @(posedge clk_sys) disable iff (reset)
      s_analog_req |=> analog_out_valid &&
        analog_out_value == $past(cell_value[analog_out_cell]);
  endproperty
  a_analog_out: assert property (p_analog_out)
    else $error("analog output does not carry the chosen cell");

  sequence s_frozen;
    !clk_en;
  endsequence
  property p_freeze;
    @(posedge clk_sys) disable iff (reset)
      s_frozen |=> held_value_out == $past(held_value_out) &&
        transfer_ack_contact == $past(transfer_ack_contact) &&
        analog_out_valid == $past(analog_out_valid);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while the clock enable was low");

  // previous edge must have advanced the history, else a deferred copy
  sequence s_steady0;
    clk_en && run_mode && $past(clk_en && run_mode) &&
      strobe_sync_r[0] == $past(strobe_sync_r[0]) &&
      !g_cell[0].u_cell.clear_pend_r;
  endsequence
  property p_no_copy_steady;
    @(posedge clk_sys) disable iff (reset)
      s_steady0 |=> cell_value[0] == $past(cell_value[0]);
  endproperty
  a_no_copy_steady: assert property (p_no_copy_steady)
    else $error("cell 0 changed under a steady trigger");

  // stop mode freezes the history, so only rises seen in run count
  sequence s_rise0;
    clk_en && run_mode && $past(run_mode) &&
      strobe_sync_r[0] && !$past(strobe_sync_r[0]);
  endsequence
  property p_copy_on_rise;
    @(posedge clk_sys) disable iff (reset)
      s_rise0 |=> cell_value[0] == $past(g_cell[0].operand);
  endproperty
  a_copy_on_rise: assert property (p_copy_on_rise)
    else $error("cell 0 missed a copy on rising trigger");

  property p_clear_nonret;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && g_cell[1].u_cell.clear_pend_r && !g_cell[1].is_ret &&
        !g_cell[1].u_cell.capture) |=> cell_value[1] == `VH_CLEAR_VALUE;
  endproperty
  a_clear_nonret: assert property (p_clear_nonret)
    else $error("non-retentive cell 1 not cleared after reset");
endmodule : value_hold_bank

// ### logic/value_hold_cell.sv
// Purpose: one edge-triggered holding cell
// Assumes: trigger already synchronised to clk_sys
// Notes: retentive cells ignore reset so their value survives it
`timescale 1ns/1ns
`include "value_hold_cfg.svh"
module value_hold_cell (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic retentive,
  input wire logic run_mode,
  input wire logic transfer_strobe,
  input wire value_hold_pkg::hold_word_t capture_operand,
  output logic transfer_ack,
  output value_hold_pkg::hold_word_t held_value_out
);
  import value_hold_pkg::*;

  logic strobe_prev_r;
  logic clear_pend_r;
  logic capture;

  // trigger history low after reset, so a high trigger then copies once
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strobe_prev_r <= 1'b0;
    end else if (clk_en && run_mode) begin
      strobe_prev_r <= transfer_strobe;
    end
  end

  // reset can't read the retention port, so clearing is deferred a cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clear_pend_r <= 1'b1;
    end else if (clk_en) begin
      clear_pend_r <= 1'b0;
    end
  end

  assign capture = run_mode && transfer_strobe && !strobe_prev_r;

  // no reset branch: value held through reset for retentive cells
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (capture) begin
        held_value_out <= capture_operand;
      end else if (clear_pend_r && !retentive) begin
        held_value_out <= `VH_CLEAR_VALUE;
      end
      // otherwise unchanged
    end
  end

  assign transfer_ack = transfer_strobe;

  property p_hold_steady;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && !capture && !clear_pend_r) |=>
        held_value_out == $past(held_value_out);
  endproperty
  a_hold_steady: assert property (p_hold_steady)
    else $error("held value changed without a rising trigger");
endmodule : value_hold_cell

// ### logic/value_hold_cfg.svh
// Purpose: constants for the bank of edge-triggered value holding cells
// Assumes: one clock domain, signed 32-bit operands
// Notes: widths, reset values and counts live here as macros
`ifndef VALUE_HOLD_CFG_SVH
`define VALUE_HOLD_CFG_SVH
`define VH_CELLS 32
`define VH_IDX_W 5
`define VH_DATA_W 32
`define VH_SEL_W 4
`define VH_RET_W 6
`define VH_CLEAR_VALUE 32'h00000000
`define VH_RET_RESET 6'h00
`define VH_SEL_RESET 4'h0
`define VH_ROUTE_RESET 2'h0
`endif

// ### logic/value_hold_pkg.sv
// Purpose: types for the value holding cell bank
// Assumes: widths from value_hold_cfg.svh
// Notes: types only, constants are macros
`include "value_hold_cfg.svh"
package value_hold_pkg;
  typedef logic signed [`VH_DATA_W-1:0] hold_word_t;
  typedef enum logic [`VH_SEL_W-1:0] {
    SRC_CONST,
    SRC_MARKER_BYTE,
    SRC_MARKER_WORD,
    SRC_MARKER_DWORD,
    SRC_ANALOG_IN_1,
    SRC_ANALOG_IN_2,
    SRC_ANALOG_IN_3,
    SRC_ANALOG_IN_4,
    SRC_ANALOG_OUT,
    SRC_BLOCK_VALUE
  } operand_src_t;
  typedef enum logic [1:0] {
    DST_ANALOG_OUT,
    DST_MARKER_BYTE,
    DST_MARKER_WORD,
    DST_MARKER_DWORD
  } value_dst_t;
endpackage : value_hold_pkg

// ### sim/block_peer.sv
// Purpose: neighbouring blocks that present analog and output words
// Assumes: words stay steady for the whole run
// Notes: alternating sign patterns and distinct low nibbles so a wrong source pick shows up
`timescale 1ns/1ns
module block_peer (
  output value_hold_pkg::hold_word_t analog_in_first,
  output value_hold_pkg::hold_word_t analog_in_second,
  output value_hold_pkg::hold_word_t analog_in_third,
  output value_hold_pkg::hold_word_t analog_in_fourth,
  output value_hold_pkg::hold_word_t analog_out_first
);
  import value_hold_pkg::*;
  assign analog_in_first = 32'h0A0A0A01;
  assign analog_in_second = 32'hF0A0A002;
  assign analog_in_third = 32'h0A0A0A03;
  assign analog_in_fourth = 32'hF0A0A004;
  assign analog_out_first = 32'h7E00000F;
endmodule : block_peer

// ### sim/value_hold_bank_tb.sv
// Purpose: self-checking bench for the holding cell bank
// Assumes: strobes held at least six cycles so sync always picks them up
// Notes: clk_en driven low in one scenario to check freezing
`timescale 1ns/1ns
`include "value_hold_cfg.svh"
module value_hold_bank_tb;
  import value_hold_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic run_mode = 1'b1;
  logic clk_en = 1'b1;
  logic [5:0] ret_cnt = 6'h00;
  logic [31:0] strobe = 32'h0;
  logic [127:0] sel = '0;
  logic [1023:0] kval = '0, md = '0, blk = '0;
  logic [255:0] mb = '0;
  logic [511:0] mw = '0;
  logic [159:0] bsel = '0;
  logic [63:0] route = '0;
  logic [4:0] ao_cell = 5'h00;
  logic ao_en = 1'b0;
  hold_word_t a1, a2, a3, a4, ao, ao_val;
  logic [31:0] ack;
  logic [1023:0] held, mdo;
  logic [255:0] mbo;
  logic [511:0] mwo;
  logic ao_vld;
  int n_fail = 0;
  int compares = 0;
  block_peer i_peer (.analog_in_first(a1), .analog_in_second(a2),
    .analog_in_third(a3), .analog_in_fourth(a4), .analog_out_first(ao));
  value_hold_bank i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .run_mode(run_mode), .retentive_count(ret_cnt),
    .transfer_strobe(strobe), .operand_select(sel), .const_operand(kval),
    .marker_byte(mb), .marker_word(mw), .marker_dword(md),
    .block_select(bsel), .block_value(blk), .analog_in_first(a1),
    .analog_in_second(a2), .analog_in_third(a3), .analog_in_fourth(a4),
    .analog_out_first(ao), .analog_out_cell(ao_cell),
    .analog_out_enable(ao_en), .output_route(route),
    .transfer_ack_contact(ack), .held_value_out(held),
    .analog_out_value(ao_val), .analog_out_valid(ao_vld),
    .marker_byte_out(mbo), .marker_word_out(mwo), .marker_dword_out(mdo));
  initial forever #4 clk_sys = ~clk_sys;
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // ack lands on edge 4, held value on edge 5, marker out on edge 6
  task automatic trig(int c);
    @(negedge clk_sys) strobe[c] = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask : trig
  task automatic untrig(int c);
    @(negedge clk_sys) strobe[c] = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : untrig
  task automatic t_capture;
    kval[31:0] = 32'h80000000;
    trig(0);
    check("ack0 high", {31'h0, ack[0]}, 32'h1);
    check("min capture", held[31:0], 32'h80000000);
    kval[31:0] = 32'h7FFFFFFF;
    repeat (6) @(negedge clk_sys);
    check("steady high", held[31:0], 32'h80000000);
    untrig(0);
    check("ack0 low", {31'h0, ack[0]}, 32'h0);
    check("held on fall", held[31:0], 32'h80000000);
    trig(0);
    check("max capture", held[31:0], 32'h7FFFFFFF);
    untrig(0);
    $display("test capture done");
  endtask : t_capture
  task automatic t_sources;
    logic [31:0] exp [11];
    kval[63:32] = 32'h11111111;
    mb[15:8] = 8'h85;
    mw[31:16] = 16'h8001;
    md[63:32] = 32'h44444444;
    bsel[9:5] = 5'h03;
    blk[127:96] = 32'h55555555;
    route[3:2] = 2'h3;
    exp = '{32'h11111111, 32'hFFFFFF85, 32'hFFFF8001, 32'h44444444,
      a1, a2, a3, a4, ao, 32'h55555555, 32'h11111111};
    for (int s = 0; s < 11; s++) begin
      sel[7:4] = s[3:0];
      trig(1);
      check("source", held[63:32], exp[s]);
      check("dword route", mdo[63:32], exp[s]);
      untrig(1);
    end
    route[3:2] = 2'h1;
    repeat (2) @(negedge clk_sys);
    check("byte route", {24'h0, mbo[15:8]}, 32'h00000011);
    route[3:2] = 2'h2;
    repeat (2) @(negedge clk_sys);
    check("word route", {16'h0, mwo[31:16]}, 32'h00001111);
    ao_cell = 5'h01;
    ao_en = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("analog route", ao_val, 32'h11111111);
    check("analog valid", {31'h0, ao_vld}, 32'h1);
    $display("test sources done");
  endtask : t_sources
  task automatic t_retain;
    ret_cnt = 6'h01;
    run_mode = 1'b0;
    kval[31:0] = 32'h12345678;
    trig(0);
    check("stop capture", held[31:0], 32'h7FFFFFFF);
    untrig(0);
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    run_mode = 1'b1;
    @(negedge clk_sys);
    check("retained", held[31:0], 32'h7FFFFFFF);
    check("cleared", held[63:32], `VH_CLEAR_VALUE);
    check("acks clear", ack, 32'h0);
    $display("test retain done");
  endtask : t_retain
  task automatic t_freeze;
    kval[95:64] = 32'h2A2A2A2A;
    clk_en = 1'b0;
    @(negedge clk_sys) strobe[2] = 1'b1;
    repeat (8) @(negedge clk_sys);
    check("frozen value", held[95:64], `VH_CLEAR_VALUE);
    check("frozen ack", {31'h0, ack[2]}, 32'h0);
    clk_en = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("thawed capture", held[95:64], 32'h2A2A2A2A);
    check("thawed ack", {31'h0, ack[2]}, 32'h1);
    untrig(2);
    $display("test freeze done");
  endtask : t_freeze
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("reset clear", held[31:0], `VH_CLEAR_VALUE);
    t_capture;
    t_sources;
    t_retain;
    t_freeze;
    complete_run;
  end
endmodule : value_hold_bank_tb
